// ---- tam_pkg.sv ----
// Constants, register map and types for the T1 alarm and status monitor
package tam_pkg;
	// ************************************************************
	// Register map (byte offsets)
	// ************************************************************
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_LIVE = 6'h04;
	localparam logic [5:0] OFF_HIST = 6'h08;
	localparam logic [5:0] OFF_ACLR = 6'h0C;
	localparam logic [5:0] OFF_ISTS = 6'h10;
	localparam logic [5:0] OFF_IMSK = 6'h14;
	localparam logic [5:0] OFF_CUR = 6'h18;
	localparam logic [5:0] OFF_TOT = 6'h1C;
	localparam logic [5:0] OFF_PER = 6'h20;
	localparam logic [5:0] OFF_IDX = 6'h24;
	localparam logic [5:0] OFF_IDAT = 6'h28;
	localparam logic [5:0] OFF_ID = 6'h2C;
	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int CTRL_ESF = 0;
	localparam int CTRL_LOOP = 1;
	localparam logic [2:0] CTRL_RST = 3'h1;
	localparam int LV_SYNC = 0;
	localparam int LV_LOS = 1;
	localparam int LV_BLUE = 2;
	localparam int LV_RED = 3;
	localparam int LV_YEL = 4;
	localparam int LV_LOOP = 5;
	localparam int LV_TEST = 7;
	localparam int AH_BLUE = 0;
	localparam int AH_RED = 1;
	localparam int AH_YEL = 2;
	localparam int EV_BLUE = 0;
	localparam int EV_RED = 1;
	localparam int EV_YEL = 2;
	localparam int EV_LOS = 3;
	localparam int EV_INTV = 4;
	localparam int EV_W = 5;
	localparam logic [6:0] IDX_RST = 7'h01;
	// Identity word, value arbitrary
	localparam logic [31:0] ID_VALUE = 32'h0000_5A5A;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ************************************************************
	// History sizing
	// ************************************************************
	localparam int HIST_DEPTH = 96;
	localparam int IDX_W = 7;
	localparam int CNT_W = 16;
	localparam int TOT_W = 32;
	// Loopback states
	typedef enum logic [1:0] {LOOP_NONE, LOOP_LOCAL, LOOP_LINE,
		LOOP_PAYLOAD} tam_loop_t;
endpackage

// ---- tam_sync.sv ----
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
module tam_sync
#(
	parameter int W = 4
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Raw pins and clean levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1; // First stage, read only by s2
	logic [W-1:0] s2; // Second stage
	logic [W-1:0] s3; // Third stage
	logic [W-1:0] next_q; // Accepted level

	// Output follows only where the late stages agree
	always_comb
	begin
		for (int i = 0; i < W; i++)
			next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
	end

	// Stage registers; stages keep running through reset
	always_ff @(posedge aclk)
	begin
		s1 <= d;
		s2 <= s1;
		s3 <= s2;
		// Flush to the pin level so no false edge follows reset
		if (!aresetn)
			q <= s3;
		else
			q <= next_q;
	end
endmodule

// ---- tam_hist.sv ----
// ESF performance counts: current interval, totals, 96-interval history
`timescale 1ns/1ps
module tam_hist
	import tam_pkg::*;
#(
	parameter int DEPTH = tam_pkg::HIST_DEPTH
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Framing and events
	input wire logic esf,
	input wire logic err_evt,
	input wire logic tick,
	// History read port
	input wire logic [tam_pkg::IDX_W-1:0] rd_idx,
	output logic [tam_pkg::CNT_W-1:0] rd_data,
	// Counts
	output logic [tam_pkg::CNT_W-1:0] cur_cnt,
	output logic [tam_pkg::TOT_W-1:0] tot_cnt,
	output logic [tam_pkg::TOT_W-1:0] tot_per
);
	logic [CNT_W-1:0] mem [DEPTH]; // Completed intervals
	logic [IDX_W-1:0] wr_ptr; // Next slot to fill
	logic [IDX_W-1:0] filled; // Valid intervals held
	logic [IDX_W-1:0] next_wr_ptr;
	logic [IDX_W-1:0] next_filled;
	logic [CNT_W-1:0] next_cur;
	logic [TOT_W-1:0] next_tot;
	logic [TOT_W-1:0] next_per;
	logic commit; // Interval closes under ESF
	logic cnt_en; // Event counted
	logic [IDX_W:0] slot; // Slot of requested interval

	// Next-state of counters and pointers
	always_comb
	begin
		commit = tick & esf;
		cnt_en = err_evt & esf;
		next_cur = (tick ? '0 : cur_cnt) + CNT_W'(cnt_en);
		next_tot = tot_cnt + TOT_W'(cnt_en);
		next_per = tot_per + TOT_W'(commit);
		next_wr_ptr = wr_ptr;
		next_filled = filled;
		if (commit)
		begin
			next_wr_ptr = (wr_ptr == IDX_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (filled != IDX_W'(DEPTH))
				next_filled = filled + 1'b1;
		end
	end

	// Index 1 is the slot just behind the write pointer
	always_comb
	begin
		slot = {1'b0, wr_ptr} + (IDX_W+1)'(DEPTH) - {1'b0, rd_idx};
		if (slot >= (IDX_W+1)'(DEPTH))
			slot = slot - (IDX_W+1)'(DEPTH);
		if (rd_idx == '0 || rd_idx > filled)
			rd_data = '0;
		else
			rd_data = mem[slot[IDX_W-1:0]];
	end

	// History store, no reset needed for the array
	always_ff @(posedge aclk)
	begin
		if (commit)
			mem[wr_ptr] <= cur_cnt;
	end

	// Counter registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr <= '0;
			filled <= '0;
			cur_cnt <= '0;
			tot_cnt <= '0;
			tot_per <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			filled <= next_filled;
			cur_cnt <= next_cur;
			tot_cnt <= next_tot;
			tot_per <= next_per;
		end
	end
endmodule

// ---- tam_top.sv ----
// T1 alarm and status monitor with AXI4-Lite register slave
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module tam_top
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [tam_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [tam_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Network receive indications (asynchronous pins)
	input wire logic rx_pulse_seen,
	input wire logic rx_frame_lock,
	input wire logic rx_ais_det,
	input wire logic rx_yellow_det,
	// Performance events (same clock)
	input wire logic err_evt,
	input wire logic interval_tick,
	// Transmit alarm responses and panel
	output logic tx_ais,
	output logic tx_yellow,
	output logic test_led,
	// Interrupt
	output logic irq
);
	import tam_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [3:0] line_q; // Clean receive levels
	logic [CNT_W-1:0] h_rd; // Selected history interval
	logic [CNT_W-1:0] h_cur; // Current interval count
	logic [TOT_W-1:0] h_tot; // Total count
	logic [TOT_W-1:0] h_per; // Completed periods
	logic aw_have; // Write address held
	logic w_have; // Write data held
	logic [ADDR_W-1:0] aw_q; // Held write address
	logic [31:0] wd_q; // Held write data
	logic ws_q; // Held low byte strobe
	logic [2:0] ctrl; // Framing and loopback select
	logic [EV_W-1:0] imask; // Interrupt mask
	logic [IDX_W-1:0] hidx; // History index select
	logic [EV_W-1:0] ists; // Interrupt status
	logic [2:0] ahist; // Alarm history
	logic [7:0] live; // Live status word
	logic next_aw_have;
	logic next_w_have;
	logic [ADDR_W-1:0] next_aw_q;
	logic [31:0] next_wd_q;
	logic next_ws_q;
	logic [2:0] next_ctrl;
	logic [EV_W-1:0] next_imask;
	logic [IDX_W-1:0] next_hidx;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [EV_W-1:0] next_ists;
	logic [2:0] next_ahist;
	logic [7:0] next_live;
	logic next_tx_ais;
	logic next_tx_yellow;
	logic next_test_led;
	logic next_irq;
	logic do_wr; // Write commits this cycle
	logic wr_ok; // Write address is mapped
	logic wl; // Low byte lane written
	logic [EV_W-1:0] ev; // Events this cycle
	logic [EV_W-1:0] w1c; // Status bits software clears
	logic aclr; // Alarm-clear request
	logic esf; // ESF framing selected
	tam_loop_t loop; // Loopback state

	// ************************************************************
	// Submodules
	// ************************************************************
	// Receive pins into the clock domain
	tam_sync #(.W(4)) tam_sync_i
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.d({rx_yellow_det, rx_ais_det, rx_frame_lock, rx_pulse_seen}),
		.q(line_q)
	);

	// Interval history and totals
	tam_hist tam_hist_i
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.esf(esf),
		.err_evt(err_evt),
		.tick(interval_tick),
		.rd_idx(hidx),
		.rd_data(h_rd),
		.cur_cnt(h_cur),
		.tot_cnt(h_tot),
		.tot_per(h_per)
	);

	// ************************************************************
	// Register bus
	// ************************************************************
	assign esf = ctrl[CTRL_ESF];
	assign loop = tam_loop_t'(ctrl[CTRL_LOOP +: 2]);

	// Mapped-offset check
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= OFF_ID);
	endfunction

	// Read data mux
	function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a);
		rd_mux = '0;
		unique case (a)
			OFF_CTRL: rd_mux = 32'(ctrl);
			OFF_LIVE: rd_mux = 32'(live);
			OFF_HIST: rd_mux = 32'(ahist);
			OFF_ISTS: rd_mux = 32'(ists);
			OFF_IMSK: rd_mux = 32'(imask);
			OFF_CUR: rd_mux = esf ? 32'(h_cur) : '0;
			OFF_TOT: rd_mux = h_tot;
			OFF_PER: rd_mux = h_per;
			OFF_IDX: rd_mux = 32'(hidx);
			OFF_IDAT: rd_mux = 32'(h_rd);
			OFF_ID: rd_mux = ID_VALUE;
			default: rd_mux = '0;
		endcase
	endfunction

	// Bus handshakes and software-written registers
	always_comb
	begin
		next_aw_have = aw_have;
		next_w_have = w_have;
		next_aw_q = aw_q;
		next_wd_q = wd_q;
		next_ws_q = ws_q;
		next_ctrl = ctrl;
		next_imask = imask;
		next_hidx = hidx;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		do_wr = aw_have & w_have & ~bvalid;
		wr_ok = mapped(aw_q);
		wl = do_wr & wr_ok & ws_q;
		// Address and data taken independently
		if (awvalid & awready)
		begin
			next_aw_have = 1'b1;
			next_aw_q = awaddr;
		end
		if (wvalid & wready)
		begin
			next_w_have = 1'b1;
			next_wd_q = wdata;
			next_ws_q = wstrb[0];
		end
		// Commit once both halves are held
		if (do_wr)
		begin
			next_aw_have = 1'b0;
			next_w_have = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bvalid & bready)
			next_bvalid = 1'b0;
		// Writable fields, low byte lane only
		if (wl && aw_q == OFF_CTRL)
			next_ctrl = wd_q[2:0];
		if (wl && aw_q == OFF_IMSK)
			next_imask = wd_q[EV_W-1:0];
		if (wl && aw_q == OFF_IDX)
			next_hidx = wd_q[IDX_W-1:0];
		// Read: one request while no answer stands
		if (arvalid & arready)
		begin
			next_rvalid = 1'b1;
			next_rdata = mapped(araddr) ? rd_mux(araddr) : '0;
			next_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid & rready)
			next_rvalid = 1'b0;
		next_awready = ~next_aw_have & ~next_bvalid;
		next_wready = ~next_w_have & ~next_bvalid;
		next_arready = ~next_rvalid;
	end

	// Bus registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= 1'b0;
			ctrl <= CTRL_RST;
			imask <= '0;
			hidx <= IDX_RST;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end
		else
		begin
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			aw_q <= next_aw_q;
			wd_q <= next_wd_q;
			ws_q <= next_ws_q;
			ctrl <= next_ctrl;
			imask <= next_imask;
			hidx <= next_hidx;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// ************************************************************
	// Alarms, history and interrupt
	// ************************************************************
	// Live status, alarm responses, latched events
	always_comb
	begin
		next_live = '0;
		next_live[LV_SYNC] = line_q[1];
		next_live[LV_LOS] = ~line_q[0];
		next_live[LV_BLUE] = line_q[2];
		next_live[LV_RED] = ~line_q[1];
		next_live[LV_YEL] = line_q[3];
		next_live[LV_LOOP +: 2] = loop;
		next_live[LV_TEST] = (loop != LOOP_NONE);
		next_tx_ais = next_live[LV_LOS];
		next_tx_yellow = next_live[LV_RED];
		next_test_led = next_live[LV_TEST];
		// Rising edges of each alarm are events
		ev = '0;
		ev[EV_BLUE] = next_live[LV_BLUE] & ~live[LV_BLUE];
		ev[EV_RED] = next_live[LV_RED] & ~live[LV_RED];
		ev[EV_YEL] = next_live[LV_YEL] & ~live[LV_YEL];
		ev[EV_LOS] = next_live[LV_LOS] & ~live[LV_LOS];
		ev[EV_INTV] = interval_tick & esf;
		aclr = wl && aw_q == OFF_ACLR && wd_q[0];
		w1c = (wl && aw_q == OFF_ISTS) ? wd_q[EV_W-1:0] : '0;
		// Clear only by request, new event wins
		next_ahist = aclr ? '0 : ahist;
		next_ahist[AH_BLUE] = next_ahist[AH_BLUE] | ev[EV_BLUE];
		next_ahist[AH_RED] = next_ahist[AH_RED] | ev[EV_RED];
		next_ahist[AH_YEL] = next_ahist[AH_YEL] | ev[EV_YEL];
		next_ists = (ists & ~w1c) | ev;
		next_irq = |(next_ists & imask);
	end

	// Alarm registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			live <= '0;
			ahist <= '0;
			ists <= '0;
			tx_ais <= 1'b0;
			tx_yellow <= 1'b0;
			test_led <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			live <= next_live;
			ahist <= next_ahist;
			ists <= next_ists;
			tx_ais <= next_tx_ais;
			tx_yellow <= next_tx_yellow;
			test_led <= next_test_led;
			irq <= next_irq;
		end
	end
endmodule

// ---- tam_top_asserts.sv ----
// Port assertions for the T1 alarm and status monitor
`timescale 1ns/1ps
module tam_top_asserts
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// Line pins and responses
	input wire logic rx_pulse_seen,
	input wire logic rx_frame_lock,
	input wire logic tx_ais,
	input wire logic tx_yellow,
	input wire logic test_led
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Settled pin gives matching transmit alarm
	property p_ais;
		$stable(rx_pulse_seen)[*8] |-> tx_ais == !rx_pulse_seen;
	endproperty
	property p_yel;
		$stable(rx_frame_lock)[*8] |-> tx_yellow == !rx_frame_lock;
	endproperty
	// Write answered two edges after the take
	property p_wans;
		awvalid && awready && wvalid && wready |-> ##2 bvalid;
	endproperty
	property p_wbusy;
		bvalid |-> !awready && !wready;
	endproperty
	property p_rans;
		arvalid && arready |=> rvalid;
	endproperty
	property p_rbusy;
		rvalid |-> !arready;
	endproperty
	// Refused read returns zero data
	property p_errz;
		rvalid && rresp != 2'h0 |-> rdata == 32'h0;
	endproperty
	// Panel lamp moves only after a register write
	property p_led;
		$changed(test_led) |-> bvalid || $past(bvalid);
	endproperty
	a_ais: assert property (p_ais) else $error("ais mismatch");
	a_yel: assert property (p_yel) else $error("yellow mismatch");
	a_wans: assert property (p_wans) else $error("no write answer");
	a_wbusy: assert property (p_wbusy) else $error("ready while busy");
	a_rans: assert property (p_rans) else $error("no read answer");
	a_rbusy: assert property (p_rbusy) else $error("arready busy");
	a_errz: assert property (p_errz) else $error("error data");
	a_led: assert property (p_led) else $error("lamp moved");
	c_ais: cover property ($rose(tx_ais));
	c_led: cover property ($rose(test_led));
	c_err: cover property (rvalid && rresp == 2'h2);
endmodule
bind tam_top tam_top_asserts tam_top_asserts_i (.aclk, .aresetn, .awvalid,
	.awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid,
	.rdata, .rresp, .rx_pulse_seen, .rx_frame_lock, .tx_ais, .tx_yellow,
	.test_led);

// ---- tam_net_model.sv ----
// Carrier network line model driving the receive indications
`timescale 1ns/1ps
module tam_net_model
(
	// Commanded line state
	input wire logic [1:0] mode,
	// Receive indications
	output logic rx_pulse_seen,
	output logic rx_frame_lock,
	output logic rx_ais_det,
	output logic rx_yellow_det
);
	// 0 dead, 1 framed, 2 unframed all-ones, 3 framed yellow
	assign rx_pulse_seen = mode != 2'h0;
	assign rx_frame_lock = mode[0];
	assign rx_ais_det = mode == 2'h2;
	assign rx_yellow_det = mode == 2'h3;
endmodule

// ---- test_tam_top.sv ----
// Register-level test bench for the T1 alarm and status monitor
`timescale 1ns/1ps
module test_tam_top;
	import tam_pkg::*;
	// ****************
	// Signals
	// ****************
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [5:0] awaddr = 6'h0, araddr = 6'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, err_evt = 1'b0;
	logic interval_tick = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, mode = 2'h0;
	logic rx_pulse_seen, rx_frame_lock, rx_ais_det, rx_yellow_det;
	logic tx_ais, tx_yellow, test_led, irq;
	logic [6:0] idx_tab [5] = '{7'h1, 7'h2, 7'h60, 7'h61, 7'h0};
	logic [31:0] hist_tab [5] = '{32'h2, 32'h3, 32'h0, 32'h0, 32'h0};
	int miscompares = 0, check_count = 0;
	// Block under test and line partner
	tam_top tam_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.rx_pulse_seen, .rx_frame_lock, .rx_ais_det, .rx_yellow_det,
		.err_evt, .interval_tick, .tx_ais, .tx_yellow, .test_led, .irq);
	tam_net_model tam_net_model_i (.mode, .rx_pulse_seen, .rx_frame_lock,
		.rx_ais_det, .rx_yellow_det);
	always #5 aclk = ~aclk;
	// ****************
	// Tasks
	// ****************
	task automatic conclude();
		$display("Checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("Error %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	// Bus write, both channels offered together
	task automatic wr(input logic [5:0] a, input logic [31:0] d,
		input logic [1:0] er = 2'h0);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 50);
		// Hung bus ends the run
		if (!bvalid)
		begin
			miscompares++;
			conclude();
		end
		bready <= 1'b0;
		chk(bresp, er);
	endtask
	// Bus read
	task automatic rd(input logic [5:0] a, output logic [31:0] d,
		input logic [1:0] er = 2'h0);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 50);
		if (!rvalid)
		begin
			miscompares++;
			conclude();
		end
		rready <= 1'b0;
		d = rdata;
		chk(rresp, er);
	endtask
	// Read and compare
	task automatic rc(input logic [5:0] a, input logic [31:0] e,
		input logic [1:0] er = 2'h0);
		logic [31:0] v;
		rd(a, v, er);
		chk(v, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// One-cycle error events or interval ticks
	task automatic pulse(input int n, input logic tk);
		repeat (n)
		begin
			@(posedge aclk);
			if (tk)
				interval_tick <= 1'b1;
			else
				err_evt <= 1'b1;
			@(posedge aclk);
			interval_tick <= 1'b0;
			err_evt <= 1'b0;
		end
	endtask
	task automatic line_to(input logic [1:0] m);
		@(posedge aclk);
		mode <= m;
		cyc(10);
	endtask
	// ****************
	// Sequence
	// ****************
	initial
	begin
		cyc(20);
		aresetn <= 1'b1;
		cyc(10);
		rc(OFF_CTRL, {29'h0, CTRL_RST});
		rc(OFF_IMSK, 32'h0);
		rc(OFF_IDX, {25'h0, IDX_RST});
		rc(OFF_ID, ID_VALUE);
		rc(OFF_LIVE, 32'hA);
		chk({tx_ais, tx_yellow}, 2'h3);
		line_to(2'h1);
		rc(OFF_LIVE, 32'h1);
		chk({tx_ais, tx_yellow}, 2'h0);
		rc(OFF_HIST, 32'h2);
		line_to(2'h2);
		rc(OFF_LIVE, 32'hC);
		line_to(2'h3);
		rc(OFF_LIVE, 32'h11);
		rc(OFF_HIST, 32'h7);
		wr(OFF_ACLR, 32'h1);
		rc(OFF_HIST, 32'h0);
		rc(OFF_LIVE, 32'h11);
		rc(OFF_ACLR, 32'h0);
		// Masked and unmasked events on the interrupt line
		wr(OFF_ISTS, 32'h1F);
		wr(OFF_IMSK, 32'h1);
		// Write with the low byte lane off has no effect
		wstrb <= 4'h0;
		wr(OFF_IMSK, 32'h1F);
		wstrb <= 4'hF;
		rc(OFF_IMSK, 32'h1);
		cyc(2);
		chk(irq, 1'b0);
		line_to(2'h2);
		chk(irq, 1'b1);
		rc(OFF_ISTS, 32'h3);
		wr(OFF_ISTS, 32'h1);
		cyc(2);
		chk(irq, 1'b0);
		line_to(2'h1);
		// Every loopback state
		for (int i = 0; i < 4; i++)
		begin
			wr(OFF_CTRL, {29'h0, i[1:0], 1'b1});
			cyc(2);
			rc(OFF_LIVE, {24'h0, i != 0, i[1:0], 5'h1});
			chk(test_led, i != 0);
		end
		wr(OFF_CTRL, 32'h1);
		// Interval counts under framing with error checks
		pulse(3, 1'b0);
		rc(OFF_CUR, 32'h3);
		pulse(1, 1'b1);
		rc(OFF_PER, 32'h1);
		pulse(2, 1'b0);
		pulse(1, 1'b1);
		for (int k = 0; k < 5; k++)
		begin
			wr(OFF_IDX, {25'h0, idx_tab[k]});
			rc(OFF_IDAT, hist_tab[k]);
		end
		rc(OFF_TOT, 32'h5);
		// Open interval holds 2 when framing moves to D4
		pulse(2, 1'b0);
		wr(OFF_CTRL, 32'h0);
		pulse(2, 1'b0);
		rc(OFF_CUR, 32'h0);
		rc(OFF_TOT, 32'h7);
		wr(OFF_CTRL, 32'h1);
		rc(OFF_CUR, 32'h2);
		// Unmapped places
		rc(6'h30, 32'h0, RESP_SLVERR);
		rc(6'h02, 32'h0, RESP_SLVERR);
		wr(6'h30, 32'h1, RESP_SLVERR);
		conclude();
	end
endmodule
